// ==== pcs_params.svh ====
// Offsets, field positions, reset values for the pulse channel error status block
`ifndef PCS_PARAMS_SVH
`define PCS_PARAMS_SVH
`define PCS_ADDR_W 5
`define PCS_DATA_W 8
`define PCS_OFF_CH0_STATUS 5'h00
`define PCS_OFF_CH1_STATUS 5'h08
`define PCS_OFF_CH0_OUTCTL 5'h09
`define PCS_OFF_CH0_CLRCTL 5'h0a
`define PCS_OFF_CH1_OUTCTL 5'h15
`define PCS_OFF_CH1_CLRCTL 5'h16
`define PCS_OFF_IRQ_STATUS 5'h1c
`define PCS_OFF_IRQ_MASK 5'h1d
`define PCS_OFF_CONFIG 5'h1e
`define PCS_BIT_UNDERVOLT 0
`define PCS_BIT_SENSOR 1
`define PCS_BIT_LOAD 2
`define PCS_BIT_PULSE 3
`define PCS_BIT_OUT_A 4
`define PCS_BIT_OUT_B 5
`define PCS_BIT_SRC_SEL 1
`define PCS_BIT_SET_A 3
`define PCS_BIT_SET_B 4
`define PCS_BIT_CLEAR 0
`define PCS_BIT_TWO_CH 0
`define PCS_RST_CTRL 8'h00
`define PCS_RST_CONFIG 8'h01
`define PCS_RST_IRQ 8'h00
`endif

// ==== pcs_pkg.sv ====
// Types shared by the pulse channel error status block
package pcs_pkg;
	// Error byte as seen by the controller, bit 7 down to bit 0
	typedef struct packed {
		logic [1:0] unused;
		logic output_b_fault_flag;
		logic output_a_fault_flag;
		logic pulse_error_flag;
		logic load_failure_flag;
		logic sensor_supply_fault_flag;
		logic supply_undervoltage_flag;
	} pcs_err_t;

	// Control bits of one channel
	typedef struct packed {
		logic output_source_select;
		logic manual_output_a_level;
		logic manual_output_b_level;
		logic fault_clear_request;
	} pcs_ctrl_t;

	// Field conditions from the output stage, one channel
	typedef struct packed {
		logic supply_present;
		logic supply_low;
		logic sensor_short;
		logic out_a_short;
		logic out_b_short;
	} pcs_cond_t;

	// Gather control bits from the output control and clear bytes
	function automatic pcs_ctrl_t pcs_ctrl_from_bytes(input logic [7:0] outctl,
		input logic [7:0] clrctl);
		pcs_ctrl_t c;
		c.output_source_select = outctl[1];
		c.manual_output_a_level = outctl[3];
		c.manual_output_b_level = outctl[4];
		c.fault_clear_request = clrctl[0];
		return c;
	endfunction : pcs_ctrl_from_bytes
endpackage : pcs_pkg

// ==== pcs_channel_flags.sv ====
// Error flags and output drive of one pulse channel
`timescale 1ns/10ps
`default_nettype none
`include "pcs_params.svh"
module pcs_channel_flags
	import pcs_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset,
	input wire pcs_ctrl_t ctrl,
	input wire pcs_cond_t cond,
	input wire logic pulse_error,
	input wire logic pulse_seq_level,
	input wire logic load_request,
	input wire logic load_single_mode,
	input wire logic load_fail,
	output var pcs_err_t flags,
	output logic digital_output_a,
	output logic digital_output_b,
	output logic load_accept,
	output logic [3:0] fault_events
);
	pcs_err_t next_flags;
	logic next_out_a;
	logic next_out_b;
	logic next_load_accept;
	logic manual_both;
	logic keep;

	// Flag and output next values
	always_comb begin
		keep = ~ctrl.fault_clear_request; // Latched flags drop while clear is held
		manual_both = ~ctrl.output_source_select & ctrl.manual_output_a_level
			& ctrl.manual_output_b_level;
		next_load_accept = load_request & ~flags.load_failure_flag;
		next_flags = '0;
		// Absent supply never reports undervoltage
		next_flags.supply_undervoltage_flag = cond.supply_present & cond.supply_low;
		next_flags.pulse_error_flag = pulse_error; // Live indication
		// Set terms come first so an event in a clear cycle is kept
		next_flags.sensor_supply_fault_flag = cond.sensor_short
			| (flags.sensor_supply_fault_flag & keep);
		next_flags.load_failure_flag = (next_load_accept & load_single_mode & load_fail)
			| (flags.load_failure_flag & keep);
		next_flags.output_a_fault_flag = cond.out_a_short
			| (flags.output_a_fault_flag & keep);
		next_flags.output_b_fault_flag = cond.out_b_short | manual_both
			| (flags.output_b_fault_flag & keep);
		// Manual drive or sequencer drive on A, B held low in sequence mode
		next_out_a = ctrl.output_source_select ? pulse_seq_level
			: ctrl.manual_output_a_level;
		next_out_b = ctrl.output_source_select ? 1'b0 : ctrl.manual_output_b_level;
	end

	// Rising of each latched flag, feeds the interrupt status
	assign fault_events = {
		next_flags.output_b_fault_flag & ~flags.output_b_fault_flag,
		next_flags.output_a_fault_flag & ~flags.output_a_fault_flag,
		next_flags.load_failure_flag & ~flags.load_failure_flag,
		next_flags.sensor_supply_fault_flag & ~flags.sensor_supply_fault_flag};

	// State registers
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			flags <= '0;
			digital_output_a <= 1'b0;
			digital_output_b <= 1'b0;
			load_accept <= 1'b0;
		end else begin
			flags <= next_flags;
			digital_output_a <= next_out_a;
			digital_output_b <= next_out_b;
			load_accept <= next_load_accept;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	sequence s_sensor_short;
		cond.sensor_short;
	endsequence
	sequence s_clear_idle;
		!ctrl.fault_clear_request [*2];
	endsequence

	a_sensor_latch_hold: assert property (s_sensor_short ##1 s_clear_idle
		|-> flags.sensor_supply_fault_flag)
		else $error("sensor supply fault not latched");
	a_undervolt_live: assert property (##1 flags.supply_undervoltage_flag
		== $past(cond.supply_present & cond.supply_low))
		else $error("undervoltage flag does not follow supply");
	a_load_refused: assert property (flags.load_failure_flag |=> !load_accept)
		else $error("load accepted while load failure pending");
	a_load_fail_set: assert property (load_request && load_single_mode && load_fail
		&& !flags.load_failure_flag |=> flags.load_failure_flag)
		else $error("load failure not flagged");
	a_pulse_follow: assert property (##1 flags.pulse_error_flag == $past(pulse_error))
		else $error("pulse error flag does not follow");
	a_out_a_latch: assert property (cond.out_a_short |=> flags.output_a_fault_flag)
		else $error("output A fault not set");
	a_out_b_manual: assert property (!ctrl.output_source_select
		&& ctrl.manual_output_a_level && ctrl.manual_output_b_level
		|=> flags.output_b_fault_flag)
		else $error("both outputs requested but output B fault not set");
	a_clear_drops: assert property (ctrl.fault_clear_request && !cond.out_a_short
		|=> !flags.output_a_fault_flag)
		else $error("clear request did not drop output A fault");
	a_seq_b_low: assert property (ctrl.output_source_select |=> !digital_output_b
		&& digital_output_a == $past(pulse_seq_level))
		else $error("sequence mode drive wrong");
endmodule : pcs_channel_flags
`default_nettype wire

// ==== pcs_error_status.sv ====
// Two-channel error status bank with register port and fault interrupt
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "pcs_params.svh"
module pcs_error_status
	import pcs_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic [`PCS_ADDR_W-1:0] reg_addr,
	input wire logic [`PCS_DATA_W-1:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [`PCS_DATA_W-1:0] reg_rdata,
	input wire logic [1:0] supply_present_pin,
	input wire logic [1:0] supply_low_pin,
	input wire logic [1:0] sensor_short_pin,
	input wire logic [1:0] out_a_short_pin,
	input wire logic [1:0] out_b_short_pin,
	input wire logic [1:0] pulse_error,
	input wire logic [1:0] pulse_seq_level,
	input wire logic [1:0] load_request,
	input wire logic [1:0] load_single_mode,
	input wire logic [1:0] load_fail,
	output logic [1:0] load_accept,
	output logic [1:0] digital_output_a,
	output logic [1:0] digital_output_b,
	output logic fault_irq
);
	// Control and configuration bytes
	logic [7:0] outctl [2];
	logic [7:0] clrctl [2];
	logic [7:0] config_reg;
	logic [7:0] irq_status;
	logic [7:0] irq_mask;
	logic [7:0] next_outctl [2];
	logic [7:0] next_clrctl [2];
	logic [7:0] next_config;
	logic [7:0] next_irq_status;
	logic [7:0] next_irq_mask;
	logic [7:0] next_rdata;
	logic next_irq;
	logic two_channels;

	// Pin synchronisers, stage one feeds only stage two
	pcs_cond_t cond_meta [2];
	pcs_cond_t cond_sync [2];
	pcs_cond_t cond_raw [2];

	// Per-channel results
	pcs_ctrl_t ctrl [2];
	pcs_err_t flags [2];
	logic [3:0] events [2];

	assign two_channels = config_reg[`PCS_BIT_TWO_CH];

	// Group the pins by channel
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			cond_raw[i].supply_present = supply_present_pin[i];
			cond_raw[i].supply_low = supply_low_pin[i];
			cond_raw[i].sensor_short = sensor_short_pin[i];
			cond_raw[i].out_a_short = out_a_short_pin[i];
			cond_raw[i].out_b_short = out_b_short_pin[i];
		end
	end

	// Two-flop synchroniser for the field conditions
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			cond_meta[0] <= '0;
			cond_meta[1] <= '0;
			cond_sync[0] <= '0;
			cond_sync[1] <= '0;
		end else begin
			cond_meta[0] <= cond_raw[0];
			cond_meta[1] <= cond_raw[1];
			cond_sync[0] <= cond_meta[0];
			cond_sync[1] <= cond_meta[1];
		end
	end

	// Channel instances; channel 1 logic keeps running in single-channel use, only its status read and events are masked
	for (genvar ch = 0; ch < 2; ch++) begin : g_ch
		assign ctrl[ch] = pcs_ctrl_from_bytes(outctl[ch], clrctl[ch]);
		pcs_channel_flags u_flags (
			.sys_clk(sys_clk),
			.reset(reset),
			.ctrl(ctrl[ch]),
			.cond(cond_sync[ch]),
			.pulse_error(pulse_error[ch]),
			.pulse_seq_level(pulse_seq_level[ch]),
			.load_request(load_request[ch]),
			.load_single_mode(load_single_mode[ch]),
			.load_fail(load_fail[ch]),
			.flags(flags[ch]),
			.digital_output_a(digital_output_a[ch]),
			.digital_output_b(digital_output_b[ch]),
			.load_accept(load_accept[ch]),
			.fault_events(events[ch])
		);
	end

	// Register writes, interrupt status and read mux
	always_comb begin
		next_outctl = outctl;
		next_clrctl = clrctl;
		next_config = config_reg;
		next_irq_mask = irq_mask;
		next_irq_status = irq_status;
		next_rdata = 8'h00;
		// Write-one-to-clear first, new events after, so an event is never lost
		if (reg_write && reg_addr == `PCS_OFF_IRQ_STATUS) begin
			next_irq_status = irq_status & ~reg_wdata;
		end
		next_irq_status = next_irq_status | {events[1] & {4{two_channels}}, events[0]};
		if (reg_write) begin
			case (reg_addr)
				`PCS_OFF_CH0_OUTCTL: next_outctl[0] = reg_wdata;
				`PCS_OFF_CH0_CLRCTL: next_clrctl[0] = reg_wdata;
				`PCS_OFF_CH1_OUTCTL: next_outctl[1] = reg_wdata;
				`PCS_OFF_CH1_CLRCTL: next_clrctl[1] = reg_wdata;
				`PCS_OFF_IRQ_MASK: next_irq_mask = reg_wdata;
				`PCS_OFF_CONFIG: next_config = reg_wdata & 8'h01;
				default: ;
			endcase
		end
		if (reg_read) begin
			case (reg_addr)
				`PCS_OFF_CH0_STATUS: next_rdata = flags[0];
				`PCS_OFF_CH1_STATUS: next_rdata = two_channels ? flags[1] : 8'h00;
				`PCS_OFF_CH0_OUTCTL: next_rdata = outctl[0];
				`PCS_OFF_CH0_CLRCTL: next_rdata = clrctl[0];
				`PCS_OFF_CH1_OUTCTL: next_rdata = outctl[1];
				`PCS_OFF_CH1_CLRCTL: next_rdata = clrctl[1];
				`PCS_OFF_IRQ_STATUS: next_rdata = irq_status;
				`PCS_OFF_IRQ_MASK: next_rdata = irq_mask;
				`PCS_OFF_CONFIG: next_rdata = config_reg;
				default: next_rdata = 8'h00; // Unmapped reads as zero
			endcase
		end
		// Level interrupt computed from next state so it stays register-timed
		next_irq = |(next_irq_status & next_irq_mask);
	end

	// Register bank state
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			outctl[0] <= `PCS_RST_CTRL;
			outctl[1] <= `PCS_RST_CTRL;
			clrctl[0] <= `PCS_RST_CTRL;
			clrctl[1] <= `PCS_RST_CTRL;
			config_reg <= `PCS_RST_CONFIG;
			irq_status <= `PCS_RST_IRQ;
			irq_mask <= `PCS_RST_IRQ;
			reg_rdata <= 8'h00;
			fault_irq <= 1'b0;
		end else begin
			outctl <= next_outctl;
			clrctl <= next_clrctl;
			config_reg <= next_config;
			irq_status <= next_irq_status;
			irq_mask <= next_irq_mask;
			reg_rdata <= next_rdata;
			fault_irq <= next_irq;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	a_ch0_read_map: assert property (reg_read && reg_addr == `PCS_OFF_CH0_STATUS
		|=> reg_rdata == $past(flags[0]))
		else $error("channel 0 status read wrong");
	a_ch1_read_off: assert property (reg_read && reg_addr == `PCS_OFF_CH1_STATUS
		&& !two_channels |=> reg_rdata == 8'h00)
		else $error("channel 1 status visible in single-channel use");
	a_irq_level: assert property (##1 fault_irq == |(irq_status & irq_mask))
		else $error("interrupt level does not match status and mask");
endmodule : pcs_error_status
`default_nettype wire

// ==== pcs_host_model.sv ====
// Host controller model driving the register port of the error status bank
`timescale 1ns/10ps
`default_nettype none
`include "pcs_params.svh"
module pcs_host_model (
	input wire logic sys_clk,
	output logic [`PCS_ADDR_W-1:0] reg_addr,
	output logic [`PCS_DATA_W-1:0] reg_wdata,
	output logic reg_write,
	output logic reg_read,
	input wire logic [`PCS_DATA_W-1:0] reg_rdata
);
	// Idle bus values
	initial begin
		reg_addr = 5'h1f;
		reg_wdata = 8'h00;
		reg_write = 1'b0;
		reg_read = 1'b0;
	end

	// One-cycle write; address and data flip afterwards so no one leans on them
	task automatic write_reg(input logic [4:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge sys_clk);
		reg_write <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask : write_reg

	// One-cycle read; data stands only in the cycle after the strobe
	task automatic read_reg(input logic [4:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge sys_clk);
		reg_read <= 1'b0;
		reg_addr <= ~a;
		#1 d = reg_rdata;
	endtask : read_reg

	// Clear pending faults before the load field is used again
	task automatic clear_faults(input int ch);
		write_reg(ch ? `PCS_OFF_CH1_CLRCTL : `PCS_OFF_CH0_CLRCTL, 8'h01);
		write_reg(ch ? `PCS_OFF_CH1_CLRCTL : `PCS_OFF_CH0_CLRCTL, 8'h00);
	endtask : clear_faults
endmodule : pcs_host_model
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench for the pulse channel error status bank
`timescale 1ns/10ps
`default_nettype none
`include "pcs_params.svh"
module tb_top;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic [4:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, rd;
	logic reg_write, reg_read, fault_irq;
	logic [1:0] sp = '0, sl = '0, ss = '0, sa = '0, sb = '0;
	logic [1:0] perr = '0, seq = '0, ldreq = '0, ldsm = 2'b11, ldfail = '0;
	logic [1:0] ldacc, dqa, dqb;
	logic [15:0] rnd = 16'd28372;
	int miscompares = 0, tests_run = 0, cycles = 0;
	int model_err[2];
	int model_irq = 0;
	logic [7:0] v;

	pcs_host_model pcs_host_model_i (.sys_clk(sys_clk), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata));
	pcs_error_status pcs_error_status_i (.sys_clk(sys_clk), .reset(reset),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata), .supply_present_pin(sp),
		.supply_low_pin(sl), .sensor_short_pin(ss), .out_a_short_pin(sa),
		.out_b_short_pin(sb), .pulse_error(perr), .pulse_seq_level(seq),
		.load_request(ldreq), .load_single_mode(ldsm), .load_fail(ldfail),
		.load_accept(ldacc), .digital_output_a(dqa), .digital_output_b(dqb),
		.fault_irq(fault_irq));

	// 200 MHz clock
	initial begin
		forever #2.5 sys_clk = ~sys_clk;
	end

	// Hang guard, well above the few hundred cycles the run needs
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			end_sim();
		end
	end

	function automatic logic [15:0] xorshift(input logic [15:0] x);
		x ^= x << 7;
		x ^= x >> 9;
		x ^= x << 8;
		return x;
	endfunction : xorshift

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic rd_chk(input logic [4:0] a, input int exp);
		pcs_host_model_i.read_reg(a, rd);
		check(rd, exp[7:0]);
	endtask : rd_chk

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : wait_cyc

	// Pin k of channel ch: 0 sensor short, 1 output A short, 2 output B short
	task automatic set_pin(input int ch, input int k, input logic lv);
		@(posedge sys_clk);
		case (k)
			0: ss[ch] <= lv;
			1: sa[ch] <= lv;
			default: sb[ch] <= lv;
		endcase
	endtask : set_pin

	// Load attempt; accept pulse stands in the cycle after the request edge
	task automatic load_try(input logic fail, input logic exp);
		@(posedge sys_clk);
		ldreq[0] <= 1'b1;
		ldfail[0] <= fail;
		@(posedge sys_clk);
		ldreq[0] <= 1'b0;
		#1 check({7'h0, ldacc[0]}, {7'h0, exp});
	endtask : load_try

	task automatic end_sim();
		$display("tests_run %0d miscompares %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_sim

	initial begin
		wait_cyc(20);
		reset <= 1'b0;
		rd_chk(`PCS_OFF_CH0_STATUS, 0);
		rd_chk(`PCS_OFF_CH1_STATUS, 0);
		// Undervoltage is live and needs the supply present
		sp[0] <= 1'b1;
		sl[0] <= 1'b1;
		wait_cyc(5);
		rd_chk(`PCS_OFF_CH0_STATUS, 8'h01);
		sp[0] <= 1'b0;
		wait_cyc(5);
		rd_chk(`PCS_OFF_CH0_STATUS, 0);
		sp[0] <= 1'b1;
		sl[0] <= 1'b0;
		wait_cyc(5);
		rd_chk(`PCS_OFF_CH0_STATUS, 0);
		perr[0] <= 1'b1;
		wait_cyc(3);
		rd_chk(`PCS_OFF_CH0_STATUS, 8'h08);
		perr[0] <= 1'b0;
		wait_cyc(3);
		rd_chk(`PCS_OFF_CH0_STATUS, 0);
		// Latched faults on both channels, held after the pin drops
		for (int ch = 0; ch < 2; ch++) begin
			for (int k = 0; k < 3; k++) begin
				set_pin(ch, k, 1'b1);
				wait_cyc(2);
				set_pin(ch, k, 1'b0);
				wait_cyc(6);
				model_err[ch] = (k == 0) ? 8'h02 : (k == 1) ? 8'h10 : 8'h20;
				model_irq |= 1 << (ch * 4 + ((k == 0) ? 0 : k + 1));
				rd_chk(ch ? `PCS_OFF_CH1_STATUS : `PCS_OFF_CH0_STATUS, model_err[ch]);
				pcs_host_model_i.clear_faults(ch);
				model_err[ch] = 0;
				rd_chk(ch ? `PCS_OFF_CH1_STATUS : `PCS_OFF_CH0_STATUS, model_err[ch]);
			end
		end
		// Failed load latches and blocks further loads until cleared
		load_try(1'b1, 1'b1);
		model_irq |= 8'h02;
		rd_chk(`PCS_OFF_CH0_STATUS, 8'h04);
		load_try(1'b0, 1'b0);
		rd_chk(`PCS_OFF_CH0_STATUS, 8'h04);
		pcs_host_model_i.clear_faults(0);
		load_try(1'b0, 1'b1);
		rd_chk(`PCS_OFF_CH0_STATUS, 0);
		// Interrupt raised only once unmasked, dropped by write-one-to-clear
		rd_chk(`PCS_OFF_IRQ_STATUS, model_irq);
		check({7'h0, fault_irq}, 8'h00);
		pcs_host_model_i.write_reg(`PCS_OFF_IRQ_MASK, 8'h22);
		wait_cyc(1);
		check({7'h0, fault_irq}, 8'h01);
		pcs_host_model_i.write_reg(`PCS_OFF_IRQ_STATUS, model_irq[7:0]);
		wait_cyc(1);
		check({7'h0, fault_irq}, 8'h00);
		rd_chk(`PCS_OFF_IRQ_STATUS, 0);
		// Random output control, first pass forces the both-high conflict
		for (int i = 0; i < 8; i++) begin
			rnd = xorshift(rnd);
			v = (i == 0) ? 8'h18 : rnd[7:0] & 8'h1a;
			seq[0] <= rnd[8];
			pcs_host_model_i.write_reg(`PCS_OFF_CH0_OUTCTL, v);
			wait_cyc(2);
			check({6'h0, dqa[0], dqb[0]}, v[1] ? {6'h0, rnd[8], 1'b0} : {6'h0, v[3], v[4]});
			rd_chk(`PCS_OFF_CH0_STATUS, (!v[1] && v[3] && v[4]) ? 8'h20 : 0);
			// Drop the conflict first, else set wins over the clear
			pcs_host_model_i.write_reg(`PCS_OFF_CH0_OUTCTL, 8'h00);
			pcs_host_model_i.clear_faults(0);
		end
		// Second channel byte hidden with one channel configured
		pcs_host_model_i.write_reg(`PCS_OFF_CONFIG, 8'h00);
		set_pin(1, 1, 1'b1);
		wait_cyc(6);
		rd_chk(`PCS_OFF_CH1_STATUS, 0);
		rd_chk(5'h03, 0);
		check({6'h0, dqa[1], dqb[1]}, 8'h00);
		end_sim();
	end
endmodule : tb_top
`default_nettype wire
